// [dao_consts.vh]
/*
 * constants for the dual converter output port: widths, latency, code points.
 * assumes inclusion by bare name from the design modules.
 */
`ifndef DAO_CONSTS_VH
`define DAO_CONSTS_VH

// ----------------------------------------
// data path
// ----------------------------------------
`define DAO_WORD_W 10
`define DAO_LATENCY 5
`define DAO_MSB 9

// ----------------------------------------
// reference code points (offset binary)
// ----------------------------------------
`define DAO_OB_ZERO 10'h200
`define DAO_OB_POS_FS 10'h3ff
`define DAO_OB_NEG_FS 10'h000

// ----------------------------------------
// reset values
// ----------------------------------------
`define DAO_WORD_RST 10'h000
// control pins park asleep with outputs released: sleep and enable-bar set
`define DAO_PIN_RST 4'ha

// ----------------------------------------
// control pin positions in the synchroniser
// ----------------------------------------
`define DAO_PIN_FMT 0
`define DAO_PIN_SLEEP 1
`define DAO_PIN_PD 2
`define DAO_PIN_OE 3

`endif

// [dao_delay_line.v]
/*
 * dao_delay_line: fixed-depth shift pipe for one converter channel word plus a valid flag.
 * assumes a single clock and synchronous active-low reset from the parent.
 */
`include "dao_consts.vh"

module dao_delay_line #(
    parameter WIDTH = `DAO_WORD_W,
    parameter DEPTH = `DAO_LATENCY
) (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // stage control
    input wire advance,
    input wire in_valid,
    input wire [WIDTH-1:0] in_word,
    // pipe end
    output wire out_valid,
    output wire [WIDTH-1:0] out_word
);

    reg [WIDTH-1:0] word_reg [0:DEPTH-1];
    reg [DEPTH-1:0] valid_reg;
    integer i;

    // ----------------------------------------
    // shift stages
    // ----------------------------------------
    // stages hold still when not advancing, so a halted pipe keeps its contents
    always @(posedge ref_clk) begin
        if (!nrst) begin
            valid_reg <= {DEPTH{1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                word_reg[i] <= {WIDTH{1'b0}};
            end
        end else if (advance) begin
            word_reg[0] <= in_word;
            valid_reg[0] <= in_valid;
            for (i = 1; i < DEPTH; i = i + 1) begin
                word_reg[i] <= word_reg[i-1];
                valid_reg[i] <= valid_reg[i-1];
            end
        end
    end

    assign out_word = word_reg[DEPTH-1];
    assign out_valid = valid_reg[DEPTH-1];

endmodule

// [dao_output_port.v]
/*
 * dao_output_port: digital side of a dual 10-bit converter. samples both channel codes each clock
 * while the converters are enabled, delays them, codes them, and drives two three-state parallel output words.
 * assumes the quantized channel codes arrive as offset binary words from converter logic
 * on ref_clk, and that control pins are asynchronous to ref_clk.
 */
// Behaviour
// - both channels are sampled together on every rising clock edge, one sample per cycle each; the code samples only while the converters are enabled.
// - each sample's word appears on the channel outputs five clock edges after it was taken.
// - output words are registered so the capture logic can take them on the next rising edge.
// - format select low gives offset binary and high gives two's complement coding.
// - offset binary full scale, zero and negative full scale map to 3ff, 200 and 000, two's to 1ff, 000, 200.
// - negative full scale gives 000 or 200 and one LSB below zero gives 1ff or 3ff.
// - while sleep is high both channels are disabled and only the bias stays enabled.
// - while power-down is high the device is in full power-down.
// - power-down with output enable low holds every output at its last presented value.
// - output enable high places all channel data outputs in high impedance.
// - two separate 10-bit words, bit 0 the LSB and bit 9 the MSB, update together.
`include "dao_consts.vh"

module dao_output_port #(
    parameter WIDTH = `DAO_WORD_W,
    parameter LATENCY = `DAO_LATENCY
) (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // quantized channel codes, offset binary, same clock
    input wire [WIDTH-1:0] chan_a_code,
    input wire [WIDTH-1:0] chan_b_code,
    // control pins, asynchronous
    input wire twos_comp_sel,
    input wire sleep_request,
    input wire full_powerdown_request,
    input wire out_enable_n,
    // power state
    output wire converters_enabled,
    output wire bias_enabled,
    output wire powered_down,
    // channel a output word
    output reg [WIDTH-1:0] chan_a_out_word,
    output wire [WIDTH-1:0] chan_a_out_oe,
    // channel b output word
    output reg [WIDTH-1:0] chan_b_out_word,
    output wire [WIDTH-1:0] chan_b_out_oe,
    // pipeline status
    output reg out_word_valid
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // the control pins come from outside this clock, so each passes two flops and
    // nothing but the second stage reads the first
    reg [3:0] pin_meta_reg;
    reg [3:0] pin_sync_reg;
    wire [3:0] pin_raw;

    assign pin_raw[`DAO_PIN_FMT] = twos_comp_sel;
    assign pin_raw[`DAO_PIN_SLEEP] = sleep_request;
    assign pin_raw[`DAO_PIN_PD] = full_powerdown_request;
    assign pin_raw[`DAO_PIN_OE] = out_enable_n;

    // reset parks the port asleep with its outputs released
    always @(posedge ref_clk) begin
        if (!nrst) begin
            pin_meta_reg <= `DAO_PIN_RST;
            pin_sync_reg <= `DAO_PIN_RST;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire fmt_twos = pin_sync_reg[`DAO_PIN_FMT];
    wire sleep_on = pin_sync_reg[`DAO_PIN_SLEEP];
    wire pd_on = pin_sync_reg[`DAO_PIN_PD];
    wire oe_off = pin_sync_reg[`DAO_PIN_OE];

    // ----------------------------------------
    // power state
    // ----------------------------------------
    localparam MODE_RUN = 2'b00;
    localparam MODE_SLEEP = 2'b01;
    localparam MODE_DOWN = 2'b10;

    // power-down outranks sleep when both pins are high
    reg [1:0] mode;
    always @* begin
        mode = MODE_RUN;
        if (pd_on) begin
            mode = MODE_DOWN;
        end else if (sleep_on) begin
            mode = MODE_SLEEP;
        end
    end

    reg conv_on;
    reg bias_on;
    always @* begin
        conv_on = 1'b0;
        bias_on = 1'b1;
        case (mode)
            MODE_RUN: begin
                conv_on = 1'b1;
            end
            MODE_SLEEP: begin
                conv_on = 1'b0;
            end
            MODE_DOWN: begin
                bias_on = 1'b0;
            end
            default: begin
                conv_on = 1'b0;
                bias_on = 1'b0;
            end
        endcase
    end

    assign converters_enabled = conv_on;
    assign bias_enabled = bias_on;
    assign powered_down = (mode == MODE_DOWN);

    // ----------------------------------------
    // coding
    // ----------------------------------------
    // offset binary to two's complement differs only in the msb
    // format select
    function [WIDTH-1:0] code_word;
        input [WIDTH-1:0] ob;
        input twos;
        begin
            code_word = {ob[WIDTH-1] ^ twos, ob[WIDTH-2:0]};
        end
    endfunction

    // every bit of a word shares one enable
    function [WIDTH-1:0] drive_mask;
        input off;
        begin
            drive_mask = {WIDTH{!off}};
        end
    endfunction

    // ----------------------------------------
    // sampling pipeline
    // ----------------------------------------
    wire [WIDTH-1:0] a_piped;
    wire [WIDTH-1:0] b_piped;
    wire a_valid;
    wire b_valid;

    // a word taken at one edge reaches the last pipe stage four edges later and
    // leaves the output latch at the fifth
    // sample every edge while the converters are enabled
    dao_delay_line #(.WIDTH(WIDTH), .DEPTH(LATENCY)) u_pipe_a (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .advance(converters_enabled),
        .in_valid(1'b1),
        .in_word(chan_a_code),
        .out_valid(a_valid),
        .out_word(a_piped)
    );

    dao_delay_line #(.WIDTH(WIDTH), .DEPTH(LATENCY)) u_pipe_b (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .advance(converters_enabled),
        .in_valid(1'b1),
        .in_word(chan_b_code),
        .out_valid(b_valid),
        .out_word(b_piped)
    );

    // ----------------------------------------
    // refill tracking
    // ----------------------------------------
    // pipe contents go stale while halted; valid stays low until refilled
    // the refill count is three bits, so a latency above seven is not supported
    localparam [2:0] FILL_FULL = LATENCY[2:0];
    reg [2:0] fill_reg;
    reg [2:0] fill_next;

    always @* begin
        fill_next = fill_reg;
        if (!converters_enabled) begin
            fill_next = 3'h0;
        end else if (fill_reg != FILL_FULL) begin
            fill_next = fill_reg + 3'h1;
        end
    end

    // ----------------------------------------
    // output latch
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (!nrst) begin
            fill_reg <= 3'h0;
            chan_a_out_word <= `DAO_WORD_RST;
            chan_b_out_word <= `DAO_WORD_RST;
            out_word_valid <= 1'b0;
        end else begin
            fill_reg <= fill_next;
            // sleep freezes the words as power-down does; a woken port replays stale stages
            // hold on power-down
            if (converters_enabled) begin
                chan_a_out_word <= code_word(a_piped, fmt_twos);
                chan_b_out_word <= code_word(b_piped, fmt_twos);
                out_word_valid <= a_valid && b_valid && (fill_reg == FILL_FULL);
            end else begin
                out_word_valid <= 1'b0;
            end
        end
    end

    assign chan_a_out_oe = drive_mask(oe_off);
    assign chan_b_out_oe = drive_mask(oe_off);

endmodule

// [dao_output_port_properties.sv]
/* checker for dao_output_port; sees only its ports, bound below */
module dao_output_port_properties #(parameter WIDTH = 10) (
    input wire ref_clk, nrst, twos_comp_sel, sleep_request, full_powerdown_request, out_enable_n,
    input wire [WIDTH-1:0] chan_a_code, chan_b_code, chan_a_out_oe, chan_b_out_oe,
    input wire converters_enabled, bias_enabled, powered_down, out_word_valid,
    input wire [WIDTH-1:0] chan_a_out_word, chan_b_out_word
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    lat_words_a: assert property (converters_enabled[*7] |->
        chan_a_out_word[8:0] == $past(chan_a_code[8:0], 6)) else $error("latency");
    fmt_twos_a: assert property ((twos_comp_sel && converters_enabled)[*8] |->
        chan_a_out_word[9] != $past(chan_a_code[9], 6)) else $error("twos msb");
    fmt_offset_a: assert property ((!twos_comp_sel && converters_enabled)[*8] |->
        chan_b_out_word[9] == $past(chan_b_code[9], 6)) else $error("offset msb");
    pd_hold_a: assert property (powered_down && $past(powered_down) |->
        $stable(chan_a_out_word) && $stable(chan_b_out_word)) else $error("pd hold");
    oe_off_a: assert property (out_enable_n[*4] |->
        chan_a_out_oe == 10'h000 && chan_b_out_oe == 10'h000) else $error("oe off");
    sleep_state_a: assert property ((sleep_request && !full_powerdown_request)[*4] |->
        !converters_enabled && bias_enabled) else $error("sleep");
    pd_state_a: assert property (full_powerdown_request[*4] |->
        powered_down && !bias_enabled && !converters_enabled) else $error("pd");
    run_state_a: assert property ((!sleep_request && !full_powerdown_request)[*4] |->
        converters_enabled) else $error("run");
    refill_wait_a: assert property (!converters_enabled ##1 converters_enabled[*6] |->
        !out_word_valid) else $error("valid early");
    refill_done_a: assert property (!converters_enabled ##1 converters_enabled[*7] |->
        out_word_valid) else $error("valid late");
endmodule
bind dao_output_port dao_output_port_properties #(.WIDTH(WIDTH)) i_props (.*);

// [dao_capture_model.sv]
/* capture logic on the far side of the word pins; assumes the design's clock */
module dao_capture_model (
    input wire ref_clk,
    input wire converters_enabled,
    input wire [9:0] a_word, a_oe, b_word, b_oe,
    output logic [9:0] cap_a = 10'h000,
    output logic [9:0] cap_b = 10'h000,
    output logic cap_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] skip = 3'h5;
    // released bits show the inverse of the last level, no pull on the wire
    wire [9:0] a_pin = (a_word & a_oe) | (~cap_a & ~a_oe);
    wire [9:0] b_pin = (b_word & b_oe) | (~cap_b & ~b_oe);
    always @(posedge ref_clk) begin
        cap_a <= a_pin;
        cap_b <= b_pin;
    end
    always @(posedge ref_clk) begin
        skip <= !converters_enabled ? 3'h5 : (skip != 3'h0 ? skip - 3'h1 : skip);
    end
    assign cap_ok = skip == 3'h0;
endmodule

// [test_dao_output_port.sv]
/* bench for dao_output_port with the capture model on its pins; one 25 MHz clock */
module test_dao_output_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, nrst = 0, twos = 0, slp = 0, pd = 0, oe_n = 0;
    logic [9:0] code_a = 10'h000, code_b = 10'h000;
    logic [9:0] tbl [4] = '{10'h3ff, 10'h200, 10'h000, 10'h1ff};
    logic [9:0] tw [4] = '{10'h1ff, 10'h000, 10'h200, 10'h3ff};
    wire [9:0] wa, wb, oa, ob, ca, cb;
    wire en, bias, pdn, vld, ok;
    int n_errors = 0, checks = 0;
    dao_output_port i_dao_output_port (.ref_clk(ref_clk), .nrst(nrst), .chan_a_code(code_a),
        .chan_b_code(code_b), .twos_comp_sel(twos), .sleep_request(slp),
        .full_powerdown_request(pd), .out_enable_n(oe_n), .converters_enabled(en),
        .bias_enabled(bias), .powered_down(pdn), .chan_a_out_word(wa), .chan_a_out_oe(oa),
        .chan_b_out_word(wb), .chan_b_out_oe(ob), .out_word_valid(vld));
    dao_capture_model i_dao_capture_model (.ref_clk(ref_clk), .converters_enabled(en),
        .a_word(wa), .a_oe(oa), .b_word(wb), .b_oe(ob), .cap_a(ca), .cap_b(cb), .cap_ok(ok));
    initial forever #20 ref_clk = ~ref_clk;
    task check(input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // boundary codes stream back to back; captured pin values lag the drive edge by seven edges
    task t_stream(input logic f);
        @(posedge ref_clk);
        twos <= f;
        tick(12);
        for (int k = 0; k < 16; k++) begin
            @(posedge ref_clk);
            code_a <= tbl[k % 4];
            code_b <= tbl[(k + 2) % 4];
            #1;
            if (k >= 7) begin
                check(ca, f ? tw[(k - 7) % 4] : tbl[(k - 7) % 4]);
                check(cb, f ? tw[(k - 5) % 4] : tbl[(k - 5) % 4]);
            end
        end
        check({9'h0, ok}, 10'h001);
        check({9'h0, vld}, 10'h001);
    endtask
    task t_hold;
        logic [9:0] h;
        logic [9:0] hb;
        @(posedge ref_clk);
        pd <= 1;
        tick(6);
        #1 h = ca;
        hb = cb;
        repeat (6) begin
            @(posedge ref_clk);
            code_a <= code_a + 10'h001;
            code_b <= code_b + 10'h001;
            #1 check(ca, h);
            check(cb, hb);
            check({7'h0, pdn, bias, en}, 10'h004);
        end
        @(posedge ref_clk);
        pd <= 0;
    endtask
    task t_sleep;
        @(posedge ref_clk);
        slp <= 1;
        tick(4);
        #1 check({7'h0, bias, en, vld}, 10'h004);
        @(posedge ref_clk);
        slp <= 0;
    endtask
    task t_oe;
        @(posedge ref_clk);
        oe_n <= 1;
        tick(4);
        #1 check(oa | ob, 10'h000);
        @(posedge ref_clk);
        oe_n <= 0;
        tick(4);
        #1 check(oa & ob, 10'h3ff);
    endtask
    task print_verdict;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        tick(8);
        nrst <= 1;
        t_stream(0);
        t_stream(1);
        t_hold;
        t_sleep;
        t_oe;
        print_verdict;
    end
    initial begin
        #100us;
        n_errors++;
        print_verdict;
    end
endmodule
